// File: inc/srq_consts.svh
// bit positions, reset values and field layouts of the status reporting block
// assumes inclusion by the package and the design file only
`ifndef SRQ_CONSTS_SVH
`define SRQ_CONSTS_SVH

`define RUN_BUSY_BIT       0
`define RUN_TRIG_WAIT_BIT  5
`define RUN_CONST_V_BIT    8
`define RUN_CONST_C_BIT    10

`define FLT_VOLT_TRIP_BIT  0
`define FLT_CURR_TRIP_BIT  1
`define FLT_OVER_TEMP_BIT  4
`define FLT_INHIBIT_BIT    9
`define FLT_UNREG_BIT      10

`define IEV_OPS_DONE_BIT   0
`define IEV_QUERY_BIT      2
`define IEV_DEVICE_BIT     3
`define IEV_PARAM_BIT      4
`define IEV_SYNTAX_BIT     5
`define IEV_POWERUP_BIT    7

`define STB_FAULT_BIT      3
`define STB_REPLY_BIT      4
`define STB_IFACE_BIT      5
`define STB_REQUEST_BIT    6
`define STB_RUN_BIT        7

`define GROUP_WIDTH        16
`define BYTE_WIDTH         8
`define RISE_PRESET_VAL    16'hffff
`define FALL_PRESET_VAL    16'h0000
`define MASK_PRESET_VAL    16'h0000
`define IEV_RESET_VAL      8'h80

`endif

// File: inc/srq_pkg.sv
// types shared by the status reporting block and its bench
// assumes srq_consts.svh is on the include path
`default_nettype none
`include "srq_consts.svh"

package srq_pkg;

	typedef enum logic [2:0] {
		CMD_NOP    = 3'h0,
		CMD_READ   = 3'h1,
		CMD_WRITE  = 3'h3,
		CMD_CLEAR  = 3'h2,
		CMD_PRESET = 3'h6,
		CMD_POLL   = 3'h7
	} cmd_kind_e;

	typedef enum logic [3:0] {
		REG_RUN_COND   = 4'h0,
		REG_RUN_RISE   = 4'h1,
		REG_RUN_FALL   = 4'h2,
		REG_RUN_EVENT  = 4'h3,
		REG_RUN_MASK   = 4'h4,
		REG_FLT_COND   = 4'h5,
		REG_FLT_RISE   = 4'h6,
		REG_FLT_FALL   = 4'h7,
		REG_FLT_EVENT  = 4'h8,
		REG_FLT_MASK   = 4'h9,
		REG_IEV_LATCH  = 4'ha,
		REG_IEV_MASK   = 4'hb,
		REG_SUMMARY    = 4'hc,
		REG_SRV_MASK   = 4'hd
	} reg_sel_e;

	typedef struct packed {
		cmd_kind_e                  kind;
		reg_sel_e                   target;
		logic [`GROUP_WIDTH-1:0]    data;
	} cmd_s;

	typedef struct packed {
		logic ops_done;
		logic query_fault;
		logic device_specific_fault;
		logic param_fault;
		logic syntax_fault;
	} iface_evt_s;

endpackage

`default_nettype wire

// File: sim/bus_ctl_model.sv
// bus controller model: queries, writes and serial polls on the command port
// assumes commands are taken on rising clk_i and answered one cycle later
`default_nettype none
module bus_ctl_model (
	// clock
	input  wire logic         clk_i,
	// command port
	output var srq_pkg::cmd_s cmd_o,
	input  wire logic [15:0]  rdata_i,
	input  wire logic         rvalid_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] last_data;
	logic        got;

	initial cmd_o = '0;

	// one command held over one edge, then the answer picked up
	task automatic send(input srq_pkg::cmd_kind_e k, input srq_pkg::reg_sel_e t, input logic [15:0] d);
		int n;
		got = 1'b0;
		n = 0;
		@(negedge clk_i);
		cmd_o = '{kind: k, target: t, data: d};
		@(negedge clk_i);
		cmd_o.kind = srq_pkg::CMD_NOP;
		if (k == srq_pkg::CMD_READ || k == srq_pkg::CMD_POLL) begin
			while (rvalid_i !== 1'b1 && n < 4) begin
				@(negedge clk_i);
				n++;
			end
			got = rvalid_i;
			last_data = rdata_i;
		end
	endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// testbench: random and corner traffic through the status reporting block
// assumes the package, the design and the bus controller model compile first
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                clk_i;
	logic                rst_i;
	logic [15:0]         run_c;
	logic [15:0]         flt_c;
	srq_pkg::iface_evt_s evt;
	logic                rep;
	srq_pkg::cmd_s       cmd;
	logic [15:0]         rdata;
	logic                rvalid;
	logic                srq;
	logic                pcf;
	logic [15:0]         rmk;
	logic [15:0]         fmk;
	logic [7:0]          imk;
	logic [7:0]          srv;
	logic [15:0]         v;
	int                  seed;
	int                  errors;
	int                  n_checks;
	srq_pkg::reg_sel_e   rw_t [8];
	int                  iev_pos [5];
	int                  run_bits [4];
	int                  flt_bits [5];

	status_reporting_service_request u_dut (
		.clk_i                 (clk_i),
		.rst_i                 (rst_i),
		.run_cond_i            (run_c),
		.fault_cond_i          (flt_c),
		.iface_evt_i           (evt),
		.reply_waiting_i       (rep),
		.poweron_clear_flag_i  (pcf),
		.iface_mask_recall_i   (8'hff),
		.service_mask_recall_i (8'hff),
		.cmd_i                 (cmd),
		.rdata_o               (rdata),
		.rvalid_o              (rvalid),
		.srq_o                 (srq)
	);
	bus_ctl_model u_ctl (.clk_i(clk_i), .cmd_o(cmd), .rdata_i(rdata), .rvalid_i(rvalid));

	always #2 clk_i = ~clk_i;

	task automatic give_verdict();
		if (errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic go(input srq_pkg::cmd_kind_e k, input srq_pkg::reg_sel_e t, input logic [15:0] d);
		u_ctl.send(k, t, d);
		if ((k == srq_pkg::CMD_READ || k == srq_pkg::CMD_POLL) && u_ctl.got !== 1'b1) begin
			errors++;
			give_verdict();
		end
	endtask

	task automatic rd(input srq_pkg::reg_sel_e t, input logic [15:0] e);
		go(srq_pkg::CMD_READ, t, 16'h0000);
		chk(u_ctl.last_data, e);
	endtask

	task automatic poll(input logic [15:0] e);
		go(srq_pkg::CMD_POLL, srq_pkg::REG_SUMMARY, 16'h0000);
		chk(u_ctl.last_data, e);
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// expected summary byte; bit 6 is the latched flag on a poll, else the live summary
	function automatic logic [15:0] stb(input logic [15:0] re, input logic [15:0] fe, input logic [7:0] ie,
			input logic pl, input logic service_request_latched);
		logic [7:0] s;
		s = 8'h00;
		s[7] = |(re & rmk);
		s[3] = |(fe & fmk);
		s[4] = rep;
		s[5] = |(ie & imk);
		s[6] = pl ? service_request_latched : |(s & srv);
		return {8'h00, s};
	endfunction

	// one group bit: rising event, query, poll, recurrence, clearing read, falling event
	task automatic grp(input logic f, input int b);
		logic [15:0] m;
		logic [3:0]  o;
		m = 16'h0001 << b;
		o = f ? 4'h5 : 4'h0;
		rmk = f ? 16'h0000 : m;
		fmk = f ? m : 16'h0000;
		srv = f ? 8'h08 : 8'h80;
		wr(srq_pkg::reg_sel_e'(4'h1 + o), m);
		wr(srq_pkg::reg_sel_e'(4'h4 + o), m);
		wr(srq_pkg::REG_SRV_MASK, {8'h00, srv});
		run_c = rmk;
		flt_c = fmk;
		wait_n(4);
		rd(srq_pkg::REG_SUMMARY, stb(rmk, fmk, 8'h00, 1'b0, 1'b0));
		chk({15'h0000, srq}, 16'h0001);
		poll(stb(rmk, fmk, 8'h00, 1'b1, 1'b1));
		chk({15'h0000, srq}, 16'h0000);
		wait_n(2);
		chk({15'h0000, srq}, 16'h0001);
		rd(srq_pkg::REG_SUMMARY, stb(rmk, fmk, 8'h00, 1'b0, 1'b0));
		rd(srq_pkg::reg_sel_e'(4'h3 + o), m);
		poll(stb(16'h0000, 16'h0000, 8'h00, 1'b1, 1'b1));
		wait_n(2);
		chk({15'h0000, srq}, 16'h0000);
		wr(srq_pkg::reg_sel_e'(4'h2 + o), m);
		run_c = 16'h0000;
		flt_c = 16'h0000;
		wait_n(4);
		rd(srq_pkg::reg_sel_e'(4'h3 + o), m);
		for (int k = 1; k < 5; k++)
			wr(srq_pkg::reg_sel_e'(k[3:0] + o), 16'h0000);
		poll(stb(16'h0000, 16'h0000, 8'h00, 1'b1, 1'b1));
		wait_n(2);
		chk({15'h0000, srq}, 16'h0000);
	endtask

	task automatic wr(input srq_pkg::reg_sel_e t, input logic [15:0] d);
		go(srq_pkg::CMD_WRITE, t, d);
	endtask

	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		run_c = 16'h0000;
		flt_c = 16'h0000;
		evt = '0;
		rep = 1'b0;
		rmk = 16'h0000;
		fmk = 16'h0000;
		imk = 8'h00;
		srv = 8'h00;
		seed = 8;
		pcf = 1'b1;
		errors = 0;
		n_checks = 0;
		rw_t = '{srq_pkg::REG_RUN_RISE, srq_pkg::REG_RUN_FALL, srq_pkg::REG_RUN_MASK, srq_pkg::REG_FLT_RISE,
			srq_pkg::REG_FLT_FALL, srq_pkg::REG_FLT_MASK, srq_pkg::REG_IEV_MASK, srq_pkg::REG_SRV_MASK};
		iev_pos = '{0, 2, 3, 4, 5};
		run_bits = '{0, 5, 8, 10};
		flt_bits = '{0, 1, 4, 9, 10};
		wait_n(8);
		rst_i = 1'b0;
		rd(srq_pkg::REG_RUN_RISE, 16'hffff);
		rd(srq_pkg::REG_FLT_RISE, 16'hffff);
		rd(srq_pkg::REG_RUN_FALL, 16'h0000);
		rd(srq_pkg::REG_IEV_MASK, 16'h0000);
		rd(srq_pkg::REG_IEV_LATCH, 16'h0080);
		rd(srq_pkg::REG_IEV_LATCH, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			if (i > 5)
				v[15:8] = 8'h00;
			wr(rw_t[i], v);
			rd(rw_t[i], v);
			wr(rw_t[i], 16'h0000);
			rd(rw_t[i], 16'h0000);
		end
		for (int i = 0; i < 4; i++) begin
			run_c = $random(seed);
			flt_c = $random(seed);
			wait_n(3);
			wr(srq_pkg::REG_RUN_COND, 16'h0000);
			rd(srq_pkg::REG_RUN_COND, run_c);
			rd(srq_pkg::REG_FLT_COND, flt_c);
		end
		run_c = 16'h0000;
		flt_c = 16'h0000;
		wait_n(4);
		foreach (run_bits[i]) grp(1'b0, run_bits[i]);
		foreach (flt_bits[i]) grp(1'b1, flt_bits[i]);
		rmk = 16'h0000;
		fmk = 16'h0000;
		srv = 8'h20;
		wr(srq_pkg::REG_SRV_MASK, 16'h0020);
		for (int i = 0; i < 5; i++) begin
			imk = 8'h01 << iev_pos[i];
			wr(srq_pkg::REG_IEV_MASK, {8'h00, imk});
			evt = srq_pkg::iface_evt_s'(5'h10 >> i);
			wait_n(1);
			evt = '0;
			wait_n(2);
			rd(srq_pkg::REG_SUMMARY, stb(16'h0000, 16'h0000, imk, 1'b0, 1'b0));
			rd(srq_pkg::REG_IEV_LATCH, {8'h00, imk});
			rd(srq_pkg::REG_IEV_LATCH, 16'h0000);
			poll(stb(16'h0000, 16'h0000, 8'h00, 1'b1, 1'b1));
		end
		wr(srq_pkg::REG_RUN_RISE, 16'h0001);
		run_c = 16'h0001;
		evt.ops_done = 1'b1;
		wait_n(1);
		evt = '0;
		wait_n(4);
		go(srq_pkg::CMD_CLEAR, srq_pkg::REG_RUN_COND, 16'h0000);
		rd(srq_pkg::REG_RUN_EVENT, 16'h0000);
		rd(srq_pkg::REG_IEV_LATCH, 16'h0000);
		rep = 1'b1;
		srv = 8'h10;
		wr(srq_pkg::REG_SRV_MASK, 16'h0010);
		rd(srq_pkg::REG_SUMMARY, stb(16'h0000, 16'h0000, 8'h00, 1'b0, 1'b0));
		srv = 8'h00;
		wr(srq_pkg::REG_SRV_MASK, 16'h0000);
		poll(stb(16'h0000, 16'h0000, 8'h00, 1'b1, 1'b1));
		wait_n(3);
		chk({15'h0000, srq}, 16'h0000);
		rd(srq_pkg::REG_SUMMARY, stb(16'h0000, 16'h0000, 8'h00, 1'b0, 1'b0));
		wr(srq_pkg::REG_RUN_FALL, 16'hffff);
		go(srq_pkg::CMD_PRESET, srq_pkg::REG_RUN_COND, 16'h0000);
		rd(srq_pkg::REG_RUN_FALL, 16'h0000);
		rd(srq_pkg::REG_RUN_RISE, 16'hffff);
		// second reset with the clear flag low: recalled masks let power-up raise a request
		pcf = 1'b0;
		rst_i = 1'b1;
		wait_n(2);
		rst_i = 1'b0;
		imk = 8'hff;
		srv = 8'hff;
		rd(srq_pkg::REG_IEV_MASK, 16'h00ff);
		rd(srq_pkg::REG_SRV_MASK, 16'h00ff);
		chk({15'h0000, srq}, 16'h0001);
		poll(stb(16'h0000, 16'h0000, 8'h80, 1'b1, 1'b1));
		give_verdict();
	end
endmodule
`default_nettype wire

// File: verilog/status_reporting_service_request.sv
// status groups, interface event latch, summary byte and service request
// assumes commands come from a parser on clk_i; condition inputs are async pins
//
// Function
// [R1] condition registers mirror live monitored signals, read-only, never cleared
// [R2] event latch captures filtered transitions, cleared by read or clear-status
// [R3] run group filters and enable mask are readable and writable
// [R4] enabled run events ORed into summary bit 7
// [R5] enabled fault events ORed into summary bit 3
// [R6] run condition bits: 0 busy, 5 trigger wait, 8 const voltage, 10 const current
// [R7] fault bits: 0 voltage, 1 current, 4 temperature, 9 inhibit, 10 unregulated
// [R8] interface event bits: 0,2,3,4,5 faults and done, 7 power-up
// [R9] summary byte: 3 fault, 4 reply, 5 interface, 6 request, 7 run
// [R10] writing zero clears filters and masks; preset also clears fall filter
// [R11] interface event latch read-only, cleared by read or clear-status
// [R12] interface mask written by command; cleared at power-up only if flag is 1
// [R13] query returns live summary in bit 6, poll returns latched request
// [R14] requesting service drives request line and latches flag in bit 6
// [R15] serial poll reports latched flag then clears it, other bits untouched
// [R16] live summary is OR of summary bits enabled by service mask
// [R17] summary query clears nothing
// [R18] reading event register clears it and its summary bit falls
// [R19] request recurs while cause persists; controller disables via masks
// [R20] service mask selects summary bits; all-zero mask never requests
// [R21] reply bit 4 set while output queue holds an unread byte
// [R22] power-up or preset sets every rise filter bit to one
// [R23] rise filter catches 0 to 1, fall filter 1 to 0, sampled on clock
`default_nettype none
`include "srq_consts.svh"

module status_reporting_service_request #(
	parameter int GW = `GROUP_WIDTH
) (
	// clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	// monitored conditions, asynchronous
	input  wire logic [GW-1:0]               run_cond_i,
	input  wire logic [GW-1:0]               fault_cond_i,
	// interface events and queue state
	input  wire srq_pkg::iface_evt_s         iface_evt_i,
	input  wire logic                        reply_waiting_i,
	// power-up recall
	input  wire logic                        poweron_clear_flag_i,
	input  wire logic [`BYTE_WIDTH-1:0]      iface_mask_recall_i,
	input  wire logic [`BYTE_WIDTH-1:0]      service_mask_recall_i,
	// command port
	input  wire srq_pkg::cmd_s               cmd_i,
	output logic [GW-1:0]                    rdata_o,
	output logic                             rvalid_o,
	// bus request line
	output logic                             srq_o
);

	initial begin
		if (GW != `GROUP_WIDTH)
			$error("group width must be 16");
	end

	logic [GW-1:0]          run_meta_reg;
	logic [GW-1:0]          run_cond_reg;
	logic [GW-1:0]          run_prev_reg;
	logic [GW-1:0]          flt_meta_reg;
	logic [GW-1:0]          flt_cond_reg;
	logic [GW-1:0]          flt_prev_reg;
	logic [GW-1:0]          run_rise_reg;
	logic [GW-1:0]          run_fall_reg;
	logic [GW-1:0]          run_event_reg;
	logic [GW-1:0]          run_mask_reg;
	logic [GW-1:0]          flt_rise_reg;
	logic [GW-1:0]          flt_fall_reg;
	logic [GW-1:0]          flt_event_reg;
	logic [GW-1:0]          flt_mask_reg;
	logic [7:0]             iev_reg;
	logic [7:0]             iev_mask_reg;
	logic [7:0]             srv_mask_reg;
	logic                   rqs_reg;
	logic [7:0]             stb_base;
	logic                   live_request_summary;
	logic                   rd;
	logic                   wr;
	logic                   cls;
	logic                   pre;
	logic                   poll;
	logic [7:0]             iev_set;

	function automatic logic [GW-1:0] capture(
		input logic [GW-1:0] cur,
		input logic [GW-1:0] prev,
		input logic [GW-1:0] rise,
		input logic [GW-1:0] fall
	);
		capture = (cur & ~prev & rise) | (~cur & prev & fall);
	endfunction

	function automatic logic [GW-1:0] widen(input logic [7:0] b);
		widen = {{(GW-8){1'b0}}, b};
	endfunction

	assign rd   = (cmd_i.kind == srq_pkg::CMD_READ);
	assign wr   = (cmd_i.kind == srq_pkg::CMD_WRITE);
	assign cls  = (cmd_i.kind == srq_pkg::CMD_CLEAR);
	assign pre  = (cmd_i.kind == srq_pkg::CMD_PRESET);
	assign poll = (cmd_i.kind == srq_pkg::CMD_POLL);

	// two-stage synchronisers for the live conditions
	always_ff @(posedge clk_i) begin
		run_meta_reg <= run_cond_i;
		run_cond_reg <= run_meta_reg; // see [R1] [R6]
		flt_meta_reg <= fault_cond_i;
		flt_cond_reg <= flt_meta_reg; // see [R1] [R7]
	end

	// previous sample for edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_prev_reg <= '0;
			flt_prev_reg <= '0;
		end else begin
			run_prev_reg <= run_cond_reg; // see [R23]
			flt_prev_reg <= flt_cond_reg;
		end
	end

	// filters and enable masks of both groups
	always_ff @(posedge clk_i) begin
		if (rst_i || pre) begin
			run_rise_reg <= `RISE_PRESET_VAL; // see [R22]
			flt_rise_reg <= `RISE_PRESET_VAL;
			run_fall_reg <= `FALL_PRESET_VAL; // see [R10]
			flt_fall_reg <= `FALL_PRESET_VAL;
			run_mask_reg <= `MASK_PRESET_VAL;
			flt_mask_reg <= `MASK_PRESET_VAL;
		end else if (wr) begin
			if (cmd_i.target == srq_pkg::REG_RUN_RISE)
				run_rise_reg <= cmd_i.data; // see [R3] [R10]
			else if (cmd_i.target == srq_pkg::REG_RUN_FALL)
				run_fall_reg <= cmd_i.data;
			else if (cmd_i.target == srq_pkg::REG_RUN_MASK)
				run_mask_reg <= cmd_i.data;
			else if (cmd_i.target == srq_pkg::REG_FLT_RISE)
				flt_rise_reg <= cmd_i.data;
			else if (cmd_i.target == srq_pkg::REG_FLT_FALL)
				flt_fall_reg <= cmd_i.data;
			else if (cmd_i.target == srq_pkg::REG_FLT_MASK)
				flt_mask_reg <= cmd_i.data;
		end
	end

	// event latches; a new event wins over the clearing read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_event_reg <= '0;
			flt_event_reg <= '0;
		end else begin
			run_event_reg <= ((cls || (rd && cmd_i.target == srq_pkg::REG_RUN_EVENT)) ? '0 : run_event_reg)
				| capture(run_cond_reg, run_prev_reg, run_rise_reg, run_fall_reg); // see [R2] [R18] [R23]
			flt_event_reg <= ((cls || (rd && cmd_i.target == srq_pkg::REG_FLT_EVENT)) ? '0 : flt_event_reg)
				| capture(flt_cond_reg, flt_prev_reg, flt_rise_reg, flt_fall_reg); // see [R2] [R18]
		end
	end

	// interface event latch
	always_comb begin
		iev_set = '0;
		iev_set[`IEV_OPS_DONE_BIT] = iface_evt_i.ops_done; // see [R8]
		iev_set[`IEV_QUERY_BIT]    = iface_evt_i.query_fault;
		iev_set[`IEV_DEVICE_BIT]   = iface_evt_i.device_specific_fault;
		iev_set[`IEV_PARAM_BIT]    = iface_evt_i.param_fault;
		iev_set[`IEV_SYNTAX_BIT]   = iface_evt_i.syntax_fault;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			iev_reg <= `IEV_RESET_VAL; // see [R8]
		else
			iev_reg <= ((cls || (rd && cmd_i.target == srq_pkg::REG_IEV_LATCH)) ? 8'h00 : iev_reg)
				| iev_set; // see [R11]
	end

	// interface mask and service mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			if (poweron_clear_flag_i) begin
				iev_mask_reg <= 8'h00; // see [R12]
				srv_mask_reg <= 8'h00;
			end else begin
				iev_mask_reg <= iface_mask_recall_i;
				srv_mask_reg <= service_mask_recall_i;
			end
		end else if (wr && cmd_i.target == srq_pkg::REG_IEV_MASK) begin
			iev_mask_reg <= cmd_i.data[7:0]; // see [R12]
		end else if (wr && cmd_i.target == srq_pkg::REG_SRV_MASK) begin
			srv_mask_reg <= cmd_i.data[7:0]; // see [R20] [R19]
		end
	end

	// summary byte without bit 6
	always_comb begin
		stb_base = '0;
		stb_base[`STB_FAULT_BIT] = |(flt_event_reg & flt_mask_reg); // see [R5] [R9]
		stb_base[`STB_REPLY_BIT] = reply_waiting_i; // see [R21]
		stb_base[`STB_IFACE_BIT] = |(iev_reg & iev_mask_reg);
		stb_base[`STB_RUN_BIT]   = |(run_event_reg & run_mask_reg); // see [R4]
	end

	assign live_request_summary = |(stb_base & srv_mask_reg); // see [R16] [R20]

	// latched request: poll clears it, a persisting cause sets it again
	always_ff @(posedge clk_i) begin
		if (rst_i)
			rqs_reg <= 1'b0;
		else if (poll)
			rqs_reg <= 1'b0; // see [R15]
		else if (live_request_summary)
			rqs_reg <= 1'b1; // see [R14] [R19]
	end

	assign srq_o = rqs_reg; // see [R14]

	// read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o  <= '0;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= rd || poll;
			if (poll) begin
				rdata_o <= widen(stb_base | {1'b0, rqs_reg, 6'h00}); // see [R13] [R15]
			end else if (rd) begin
				if (cmd_i.target == srq_pkg::REG_RUN_COND)
					rdata_o <= run_cond_reg; // see [R1]
				else if (cmd_i.target == srq_pkg::REG_RUN_RISE)
					rdata_o <= run_rise_reg; // see [R3]
				else if (cmd_i.target == srq_pkg::REG_RUN_FALL)
					rdata_o <= run_fall_reg;
				else if (cmd_i.target == srq_pkg::REG_RUN_EVENT)
					rdata_o <= run_event_reg;
				else if (cmd_i.target == srq_pkg::REG_RUN_MASK)
					rdata_o <= run_mask_reg;
				else if (cmd_i.target == srq_pkg::REG_FLT_COND)
					rdata_o <= flt_cond_reg;
				else if (cmd_i.target == srq_pkg::REG_FLT_RISE)
					rdata_o <= flt_rise_reg;
				else if (cmd_i.target == srq_pkg::REG_FLT_FALL)
					rdata_o <= flt_fall_reg;
				else if (cmd_i.target == srq_pkg::REG_FLT_EVENT)
					rdata_o <= flt_event_reg;
				else if (cmd_i.target == srq_pkg::REG_FLT_MASK)
					rdata_o <= flt_mask_reg;
				else if (cmd_i.target == srq_pkg::REG_IEV_LATCH)
					rdata_o <= widen(iev_reg); // see [R11]
				else if (cmd_i.target == srq_pkg::REG_IEV_MASK)
					rdata_o <= widen(iev_mask_reg);
				else if (cmd_i.target == srq_pkg::REG_SUMMARY)
					rdata_o <= widen(stb_base | {1'b0, live_request_summary, 6'h00}); // see [R13] [R17]
				else if (cmd_i.target == srq_pkg::REG_SRV_MASK)
					rdata_o <= widen(srv_mask_reg);
				else
					rdata_o <= '0;
			end
		end
	end

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	cond_mirror_a: assert property (
		##2 run_cond_reg == $past(run_cond_i, 2)) // see [R1]
		else $error("run condition does not follow input");

	event_clear_a: assert property (
		(rd && cmd_i.target == srq_pkg::REG_RUN_EVENT
			&& capture(run_cond_reg, run_prev_reg, run_rise_reg, run_fall_reg) == '0)
		|=> run_event_reg == '0) // see [R2] [R18]
		else $error("run event latch not cleared by read");

	rise_capture_a: assert property (
		(|(run_cond_reg & ~run_prev_reg & run_rise_reg)) && !cls
		|=> |(run_event_reg & $past(run_cond_reg & ~run_prev_reg & run_rise_reg))) // see [R23]
		else $error("rising edge not latched");

	run_summary_a: assert property (
		rvalid_o && $past(poll) |-> rdata_o[`STB_RUN_BIT] == $past(|(run_event_reg & run_mask_reg))) // see [R4]
		else $error("run summary bit wrong");

	fault_summary_a: assert property (
		stb_base[`STB_FAULT_BIT] == |(flt_event_reg & flt_mask_reg)) // see [R5]
		else $error("fault summary bit wrong");

	mask_zero_a: assert property (
		srv_mask_reg == 8'h00 && !rqs_reg |=> !srq_o) // see [R20]
		else $error("request raised with empty mask");

	poll_clear_a: assert property (
		poll |=> rvalid_o && rdata_o[`STB_REQUEST_BIT] == $past(rqs_reg) && !rqs_reg) // see [R15] [R13]
		else $error("poll did not report and clear request");

	query_live_a: assert property (
		rd && cmd_i.target == srq_pkg::REG_SUMMARY |=> rdata_o[`STB_REQUEST_BIT] == $past(live_request_summary)
			&& ($stable(rqs_reg) || $past(live_request_summary))) // see [R13] [R17]
		else $error("summary query bit 6 wrong");

	request_recur_a: assert property (
		live_request_summary && !poll |=> srq_o) // see [R14] [R19]
		else $error("request not raised");

	preset_rise_a: assert property (
		pre |=> run_rise_reg == `RISE_PRESET_VAL && flt_fall_reg == `FALL_PRESET_VAL) // see [R22] [R10]
		else $error("preset values wrong");

	cls_iev_a: assert property (
		cls && iev_set == 8'h00 |=> iev_reg == 8'h00) // see [R11]
		else $error("clear-status left interface events");

	poll_seen_c: cover property (srq_o ##1 poll ##1 rvalid_o);
	recur_c: cover property (poll ##1 live_request_summary ##1 srq_o);
	fall_event_c: cover property (|capture(flt_cond_reg, flt_prev_reg, '0, flt_fall_reg));
	iface_req_c: cover property (stb_base[`STB_IFACE_BIT] && srv_mask_reg[`STB_IFACE_BIT] ##1 srq_o);

endmodule

`default_nettype wire
